// ---- latching_point_distributor.sv ----
`timescale 1ns/10ps
// Function
// - order is 16 bits: 12 point bits and 4 function bits
// - functions are operate, release, test mode and reset to idle
// - orders are taken from either bus with no preference
// - orders are captured only while the enable lead is high
// - point bits and three function bits stay held until completion
// - stored point code selects exactly one of 255 points, none in test mode
// - code is checked before any operate or release drive
// - only one point is driven per order
// - drive ends on matching feedback; selection drops and unit idles in the same cycle
// - a successful order completes within 25 ms
// - without confirmation in time the unit stays busy
// - busy, invalid code, test mode, not confirmed always shown
// - test mode exercises an internal maintenance point
module latching_point_distributor import lat_pkg::*; #(
	parameter int CONFIRM_CYC = CONFIRM_LIMIT_CYC,
	parameter int ORDER_CYC = ORDER_LIMIT_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// duplicated peripheral buses and enable lead
	input wire logic [ORDER_W-1:0] busAWord,
	input wire logic busAStrobe,
	input wire logic [ORDER_W-1:0] busBWord,
	input wire logic busBStrobe,
	input wire logic enableLead,
	// end point side
	output logic [POINT_COUNT-1:0] pointSelect,
	output logic driveOperate,
	output logic driveRelease,
	input wire logic pointFeedback,
	// status outputs
	output logic statusBusy,
	output logic statusInvalid,
	output logic statusTest,
	output logic statusNotConfirmed,
	// register port
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdData,
	output logic irq
);
	state_t state_reg, state_next;
	logic [POINT_W-1:0] pointCode_reg;
	logic [2:0] func_reg;
	logic orderOk_reg;
	logic target_reg;
	logic maintLatch_reg;
	logic [EV_W-1:0] irqStat_reg, irqMask_reg;
	logic accept, bothDiffer, resetOrder, wordOk, confirm, fbLevel;
	logic [ORDER_W-1:0] word;
	logic [POINT_W-1:0] wordPoint;
	logic [FUNC_W-1:0] wordFunc;
	logic [EV_W-1:0] events;
	logic startDrive;
	lat_timer_if tif ();

	// either bus, gated by the enable lead
	assign accept = enableLead && (busAStrobe || busBStrobe);
	assign word = busAStrobe ? busAWord : busBWord;
	assign bothDiffer = busAStrobe && busBStrobe && (busAWord != busBWord);
	assign wordPoint = word[POINT_W-1:0];
	assign wordFunc = word[ORDER_W-1:POINT_W];
	assign wordOk = isOneHot4(wordFunc) && (wordPoint <= POINT_MAX)
		&& !bothDiffer;
	assign resetOrder = accept && wordOk && wordFunc[FN_RESET];

	// maintenance point stands in for the field point in
	assign fbLevel = func_reg[FN_TEST] ? maintLatch_reg : pointFeedback;
	assign confirm = (state_reg == S_DRIVE) && (fbLevel == target_reg);
	assign startDrive = (state_reg == S_CHECK) && orderOk_reg;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			S_IDLE: begin
				if (accept) begin
					state_next = S_CHECK;
				end
			end
			S_CHECK: begin
				state_next = orderOk_reg ? S_DRIVE : S_IDLE;
			end
			S_DRIVE: begin
				if (confirm) begin
					state_next = S_IDLE;
				end else if (tif.expired) begin
					state_next = S_STUCK;
				end
			end
			S_STUCK: begin
				state_next = S_STUCK;
			end
		endcase
		if (resetOrder) begin
			state_next = S_IDLE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_reg <= S_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// order storage held until completion
	always_ff @(posedge core_clk) begin
		if (!resetn || resetOrder || confirm) begin
			pointCode_reg <= '0;
			func_reg <= '0;
			orderOk_reg <= 1'b0;
		end else if (state_reg == S_IDLE && accept) begin
			pointCode_reg <= wordPoint;
			func_reg <= wordFunc[2:0];
			orderOk_reg <= wordOk;
		end
	end

	// target level and drive, one point at a time
	always_ff @(posedge core_clk) begin
		if (!resetn || resetOrder) begin
			target_reg <= 1'b0;
			driveOperate <= 1'b0;
			driveRelease <= 1'b0;
		end else if (startDrive) begin
			target_reg <= func_reg[FN_TEST] ? !maintLatch_reg
				: func_reg[FN_OPERATE];
			driveOperate <= func_reg[FN_OPERATE];
			driveRelease <= func_reg[FN_RELEASE];
		end else if (confirm || tif.expired) begin
			driveOperate <= 1'b0;
			driveRelease <= 1'b0;
		end
	end

	// internal maintenance latching point
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			maintLatch_reg <= 1'b0;
		end else if (state_reg == S_DRIVE && func_reg[FN_TEST]) begin
			maintLatch_reg <= target_reg;
		end
	end

	assign tif.run = (state_reg == S_DRIVE);
	lat_confirm_timer #(.LIMIT_CYC(CONFIRM_CYC)) u_timer (
		.core_clk(core_clk),
		.resetn(resetn),
		.tif(tif)
	);

	lat_point_decoder #(.POINTS(POINT_COUNT)) u_decoder (
		.core_clk(core_clk),
		.resetn(resetn),
		.load(startDrive && !func_reg[FN_TEST]),
		.clear(resetOrder || confirm),
		.code(pointCode_reg),
		.pointSelect(pointSelect)
	);

	// status flags
	always_ff @(posedge core_clk) begin
		if (!resetn || resetOrder) begin
			statusBusy <= 1'b0;
			statusInvalid <= 1'b0;
			statusTest <= 1'b0;
			statusNotConfirmed <= 1'b0;
		end else begin
			statusBusy <= (state_next != S_IDLE);
			if (state_reg == S_IDLE && accept) begin
				statusInvalid <= 1'b0;
				statusTest <= 1'b0;
				statusNotConfirmed <= 1'b0;
			end else if (state_reg == S_CHECK) begin
				statusInvalid <= !orderOk_reg;
				statusTest <= orderOk_reg && func_reg[FN_TEST];
			end else if (tif.expired && !confirm) begin
				statusNotConfirmed <= 1'b1;
			end
		end
	end

	// interrupts: sticky, write one to clear, set wins
	assign events[EV_DONE] = confirm;
	assign events[EV_INVALID] = (state_reg == S_CHECK) && !orderOk_reg;
	assign events[EV_TIMEOUT] = tif.expired && !confirm;
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			irqStat_reg <= EV_RESET_VAL;
		end else begin
			irqStat_reg <= (irqStat_reg & ~((regWrite
				&& regAddr == REG_IRQ_STAT) ? regWrData[EV_W-1:0]
				: EV_RESET_VAL)) | events;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			irqMask_reg <= EV_RESET_VAL;
		end else if (regWrite && regAddr == REG_IRQ_MASK) begin
			irqMask_reg <= regWrData[EV_W-1:0];
		end
	end
	assign irq = |(irqStat_reg & irqMask_reg);

	always_ff @(posedge core_clk) begin
		if (!resetn || !regRead) begin
			regRdData <= '0;
		end else begin
			unique case (regAddr)
				REG_STATUS: regRdData <= {28'h0, statusNotConfirmed,
					statusTest, statusInvalid, statusBusy};
				REG_IRQ_STAT: regRdData <= {29'h0, irqStat_reg};
				REG_IRQ_MASK: regRdData <= {29'h0, irqMask_reg};
				default: regRdData <= '0;
			endcase
		end
	end

	// helper counters for assertions
	logic [CNT_W-1:0] busyCnt, driveCnt;
	always_ff @(posedge core_clk) begin
		if (!resetn || state_reg == S_IDLE) begin
			busyCnt <= '0;
		end else if (busyCnt != '1) begin
			busyCnt <= busyCnt + 1'b1;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!resetn || state_reg != S_DRIVE) begin
			driveCnt <= '0;
		end else begin
			driveCnt <= driveCnt + 1'b1;
		end
	end

	property p_reset_order;
		@(posedge core_clk) disable iff (!resetn)
		resetOrder |=> state_reg == S_IDLE && !statusBusy && !driveOperate;
	endproperty
	a_reset_order: assert property (p_reset_order)
		else $error("reset order did not idle the unit");

	property p_no_enable;
		@(posedge core_clk) disable iff (!resetn)
		state_reg == S_IDLE && !enableLead |=> state_reg == S_IDLE;
	endproperty
	a_no_enable: assert property (p_no_enable)
		else $error("order taken without enable");

	property p_bus_b;
		@(posedge core_clk) disable iff (!resetn)
		state_reg == S_IDLE && enableLead && busBStrobe && !busAStrobe
			&& !resetOrder
			|=> pointCode_reg == $past(busBWord[POINT_W-1:0]);
	endproperty
	a_bus_b: assert property (p_bus_b)
		else $error("order on second bus not captured");

	property p_invalid_no_drive;
		@(posedge core_clk) disable iff (!resetn)
		state_reg == S_CHECK && !orderOk_reg && !resetOrder
			|=> !driveOperate && !driveRelease ##1 statusInvalid;
	endproperty
	a_invalid_no_drive: assert property (p_invalid_no_drive)
		else $error("invalid code drove a point");

	property p_single_point;
		@(posedge core_clk) disable iff (!resetn)
		!(driveOperate && driveRelease) && $onehot0(pointSelect);
	endproperty
	a_single_point: assert property (p_single_point)
		else $error("more than one point or drive active");

	property p_confirm_idle;
		@(posedge core_clk) disable iff (!resetn)
		confirm |=> state_reg == S_IDLE && !driveOperate && !driveRelease
			##1 pointSelect == '0;
	endproperty
	a_confirm_idle: assert property (p_confirm_idle)
		else $error("confirmation did not release the point");

	property p_stuck;
		@(posedge core_clk) disable iff (!resetn)
		state_reg == S_STUCK && !resetOrder
			|=> state_reg == S_STUCK && statusBusy && statusNotConfirmed;
	endproperty
	a_stuck: assert property (p_stuck)
		else $error("unit left busy without confirmation");

	property p_hold;
		@(posedge core_clk) disable iff (!resetn)
		state_reg != S_IDLE && !resetOrder && !confirm
			|=> $stable(pointCode_reg) && $stable(func_reg);
	endproperty
	a_hold: assert property (p_hold)
		else $error("stored order changed while busy");

	property p_order_bound;
		@(posedge core_clk) disable iff (!resetn)
		(state_reg == S_CHECK || state_reg == S_DRIVE)
			|-> busyCnt < CNT_W'(ORDER_CYC);
	endproperty
	a_order_bound: assert property (p_order_bound)
		else $error("order exceeded completion bound");

	property p_timeout_at;
		@(posedge core_clk) disable iff (!resetn)
		tif.expired |-> driveCnt == CNT_W'(CONFIRM_CYC - 1);
	endproperty
	a_timeout_at: assert property (p_timeout_at)
		else $error("confirmation limit off count");

	property p_status;
		@(posedge core_clk) disable iff (!resetn)
		state_reg == S_CHECK && orderOk_reg && !resetOrder
			|=> statusBusy && statusTest == $past(func_reg[FN_TEST]);
	endproperty
	a_status: assert property (p_status)
		else $error("status flags wrong after check");

	c_done: cover property (@(posedge core_clk) disable iff (!resetn)
		confirm && !func_reg[FN_TEST]);
	c_test: cover property (@(posedge core_clk) disable iff (!resetn)
		confirm && func_reg[FN_TEST]);
	c_invalid: cover property (@(posedge core_clk) disable iff (!resetn)
		events[EV_INVALID]);
	c_stuck: cover property (@(posedge core_clk) disable iff (!resetn)
		state_reg == S_STUCK ##1 resetOrder);
endmodule

// ---- lat_pkg.sv ----
package lat_pkg;
	// order word layout
	localparam int ORDER_W = 16;
	localparam int POINT_W = 12;
	localparam int FUNC_W = 4;
	localparam int POINT_COUNT = 255;
	localparam int FN_OPERATE = 0;
	localparam int FN_RELEASE = 1;
	localparam int FN_TEST = 2;
	localparam int FN_RESET = 3;
	localparam logic [POINT_W-1:0] POINT_MAX = 12'h0fe;
	// timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int ORDER_LIMIT_NS = 25000000;
	localparam int CONFIRM_LIMIT_NS = 20000000;
	localparam int ORDER_LIMIT_CYC = ORDER_LIMIT_NS / CLK_PERIOD_NS;
	localparam int CONFIRM_LIMIT_CYC = CONFIRM_LIMIT_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 23;
	// register map
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h4;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h8;
	localparam int SB_BUSY = 0;
	localparam int SB_INVALID = 1;
	localparam int SB_TEST = 2;
	localparam int SB_NOCONF = 3;
	localparam int EV_W = 3;
	localparam int EV_DONE = 0;
	localparam int EV_INVALID = 1;
	localparam int EV_TIMEOUT = 2;
	localparam logic [EV_W-1:0] EV_RESET_VAL = 3'h0;
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_CHECK = 2'b01,
		S_DRIVE = 2'b10,
		S_STUCK = 2'b11
	} state_t;
	function automatic logic isOneHot4(input logic [FUNC_W-1:0] f);
		return (f != 4'h0) && ((f & (f - 4'h1)) == 4'h0);
	endfunction
endpackage

// ---- lat_timer_if.sv ----
`timescale 1ns/10ps
interface lat_timer_if;
	logic run;
	logic expired;
	modport ctrl (output run, input expired);
	modport timer (input run, output expired);
endinterface

// ---- lat_confirm_timer.sv ----
`timescale 1ns/10ps
module lat_confirm_timer import lat_pkg::*; #(
	parameter int LIMIT_CYC = CONFIRM_LIMIT_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// control side
	lat_timer_if.timer tif
);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT_CYC - 1);
	logic [CNT_W-1:0] cnt_reg;
	logic done_reg;
	// counts only while the unit is in S_DRIVE, test mode included
	always_ff @(posedge core_clk) begin
		if (!resetn || !tif.run) begin
			cnt_reg <= '0;
			done_reg <= 1'b0;
		end else if (cnt_reg != LAST) begin
			cnt_reg <= cnt_reg + 1'b1;
		end else begin
			done_reg <= 1'b1;
		end
	end
	assign tif.expired = tif.run && (cnt_reg == LAST) && !done_reg;
endmodule

// ---- lat_point_decoder.sv ----
`timescale 1ns/10ps
module lat_point_decoder import lat_pkg::*; #(
	parameter int POINTS = POINT_COUNT
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// control
	input wire logic load,
	input wire logic clear,
	input wire logic [POINT_W-1:0] code,
	// select lines
	output logic [POINTS-1:0] pointSelect
);
	// one line out of POINTS, none for codes out of range
	always_ff @(posedge core_clk) begin
		if (!resetn || clear) begin
			pointSelect <= '0;
		end else if (load) begin
			for (int i = 0; i < POINTS; i++) begin
				pointSelect[i] <= (code == POINT_W'(i));
			end
		end
	end
endmodule

// ---- order_source.sv ----
`timescale 1ns/10ps
module order_source import lat_pkg::*; (
	// clock
	input wire logic core_clk,
	// duplicated peripheral buses and enable lead
	output logic [ORDER_W-1:0] busAWord,
	output logic busAStrobe,
	output logic [ORDER_W-1:0] busBWord,
	output logic busBStrobe,
	output logic enableLead
);
	initial begin
		busAWord = 16'h0000;
		busBWord = 16'h0000;
		busAStrobe = 1'b0;
		busBStrobe = 1'b0;
		enableLead = 1'b0;
	end
	// broadcast one order; sel bit 0 strobes bus a, bit 1 bus b
	task automatic issue(input logic [ORDER_W-1:0] word,
		input logic [1:0] sel, input logic en);
		@(posedge core_clk);
		busAWord <= word;
		busBWord <= word;
		busAStrobe <= sel[0];
		busBStrobe <= sel[1];
		enableLead <= en;
		@(posedge core_clk);
		busAStrobe <= 1'b0;
		busBStrobe <= 1'b0;
		enableLead <= 1'b0;
		// released bus no longer shows the order
		busAWord <= ~word;
		busBWord <= ~word;
	endtask
	// both buses strobed together with differing words
	task automatic issueClash(input logic [ORDER_W-1:0] wordA,
		input logic [ORDER_W-1:0] wordB);
		@(posedge core_clk);
		busAWord <= wordA;
		busBWord <= wordB;
		busAStrobe <= 1'b1;
		busBStrobe <= 1'b1;
		enableLead <= 1'b1;
		@(posedge core_clk);
		busAStrobe <= 1'b0;
		busBStrobe <= 1'b0;
		enableLead <= 1'b0;
		busAWord <= ~wordA;
		busBWord <= ~wordB;
	endtask
endmodule

// ---- latching_point_distributor_tb.sv ----
`timescale 1ns/10ps
module latching_point_distributor_tb import lat_pkg::*;;
	localparam int CONF = 20;
	localparam int ORD = 40;
	logic core_clk, resetn, pointFeedback, stall;
	logic [ORDER_W-1:0] busAWord, busBWord;
	logic busAStrobe, busBStrobe, enableLead;
	logic [POINT_COUNT-1:0] pointSelect, latched;
	logic driveOperate, driveRelease, irq;
	logic statusBusy, statusInvalid, statusTest, statusNotConfirmed;
	logic [ADDR_W-1:0] regAddr = 4'h0;
	logic [31:0] regWrData = 32'h0, regRdData, rd;
	logic regWrite = 1'b0, regRead = 1'b0;
	int miscompares = 0, comparisons = 0, cyc = 0, fbWait = 0, n;
	order_source u_cpu (.core_clk(core_clk), .busAWord(busAWord),
		.busAStrobe(busAStrobe), .busBWord(busBWord),
		.busBStrobe(busBStrobe), .enableLead(enableLead));
	latching_point_distributor #(.CONFIRM_CYC(CONF), .ORDER_CYC(ORD)) u_dut (
		.core_clk(core_clk), .resetn(resetn), .busAWord(busAWord),
		.busAStrobe(busAStrobe), .busBWord(busBWord), .busBStrobe(busBStrobe),
		.enableLead(enableLead), .pointSelect(pointSelect),
		.driveOperate(driveOperate), .driveRelease(driveRelease),
		.pointFeedback(pointFeedback), .statusBusy(statusBusy),
		.statusInvalid(statusInvalid), .statusTest(statusTest),
		.statusNotConfirmed(statusNotConfirmed), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .irq(irq));
	// field latches change state three cycles into the drive
	initial latched = '0;
	initial stall = 1'b0;
	always @(posedge core_clk) begin
		if ((driveOperate || driveRelease) && !stall) begin
			fbWait <= fbWait + 1;
			if (fbWait == 2 && driveOperate)
				latched <= latched | pointSelect;
			if (fbWait == 2 && driveRelease)
				latched <= latched & ~pointSelect;
		end else
			fbWait <= 0;
	end
	assign pointFeedback = |pointSelect ? |(latched & pointSelect) : cyc[0];
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic regWr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask
	task automatic regRd(input logic [ADDR_W-1:0] a);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1 rd = regRdData;
	endtask
	task automatic waitIdle();
		n = 0;
		do begin
			@(posedge core_clk);
			#1 n++;
		end while (statusBusy !== 1'b0 && n < 200);
	endtask
	task automatic runPoint(input logic [15:0] w, input logic [1:0] sel,
		input int pt, input logic op);
		u_cpu.issue(w, sel, 1'b1);
		repeat (3) @(posedge core_clk);
		#1 check({statusBusy, driveOperate, driveRelease}, {1'b1, op, !op});
		check(pointSelect === (255'h1 << pt), 1);
		waitIdle();
		check(n < ORD, 1);
		check(latched[pt], op);
		check({driveOperate, driveRelease, statusInvalid}, 0);
		check(|pointSelect, 0);
	endtask
	task automatic t_reset();
		check({statusBusy, statusInvalid, statusTest, statusNotConfirmed}, 0);
		regRd(REG_IRQ_MASK);
		check(rd, 0);
		regRd(REG_IRQ_STAT);
		check(rd, EV_RESET_VAL);
	endtask
	task automatic t_points();
		runPoint(16'h1005, 2'b01, 5, 1'b1);
		runPoint(16'h2005, 2'b10, 5, 1'b0);
		runPoint(16'h10fe, 2'b11, 254, 1'b1);
	endtask
	task automatic t_enable();
		u_cpu.issue(16'h1006, 2'b01, 1'b0);
		repeat (4) @(posedge core_clk);
		#1 check({statusBusy, driveOperate}, 0);
	endtask
	task automatic t_invalid();
		logic [15:0] bad [4] = '{16'h3005, 16'h0005, 16'h10ff, 16'h1100};
		foreach (bad[i]) begin
			u_cpu.issue(bad[i], 2'b01, 1'b1);
			repeat (4) @(posedge core_clk);
			#1 check({statusInvalid, statusBusy, driveOperate}, 3'h4);
			check(|pointSelect, 0);
		end
		u_cpu.issueClash(16'h1005, 16'h1006);
		repeat (4) @(posedge core_clk);
		#1 check({statusInvalid, statusBusy, driveOperate}, 3'h4);
		check(|pointSelect, 0);
		regRd(REG_IRQ_STAT);
		check(rd[EV_INVALID], 1);
	endtask
	task automatic t_test();
		u_cpu.issue(16'h4000, 2'b01, 1'b1);
		repeat (3) @(posedge core_clk);
		#1 check({pointSelect !== 0, driveOperate, driveRelease}, 0);
		waitIdle();
		check({statusTest, statusNotConfirmed, statusBusy}, 3'h4);
	endtask
	task automatic t_timeout();
		stall = 1'b1;
		u_cpu.issue(16'h1007, 2'b01, 1'b1);
		repeat (CONF + 10) @(posedge core_clk);
		#1 check({statusNotConfirmed, statusBusy, driveOperate}, 3'h6);
		u_cpu.issue(16'h2007, 2'b10, 1'b1);
		repeat (4) @(posedge core_clk);
		#1 check({statusBusy, driveRelease}, 2'h2);
		regRd(REG_IRQ_STAT);
		check(rd[EV_TIMEOUT], 1);
		u_cpu.issue(16'h8000, 2'b10, 1'b1);
		repeat (4) @(posedge core_clk);
		#1 check({statusBusy, statusNotConfirmed, statusTest}, 0);
		check(|pointSelect, 0);
		stall = 1'b0;
	endtask
	task automatic t_irq();
		regWr(REG_IRQ_STAT, 32'h7);
		#1 check(irq, 0);
		runPoint(16'h1009, 2'b01, 9, 1'b1);
		check(irq, 0);
		regWr(REG_IRQ_MASK, 32'h1);
		#1 check(irq, 1);
		regWr(REG_IRQ_STAT, 32'h1);
		#1 check(irq, 0);
		regWr(4'hc, 32'hff);
		regRd(4'hc);
		check(rd, 0);
		regRd(REG_IRQ_MASK);
		check(rd, 1);
		regRd(REG_STATUS);
		check(rd, 0);
	endtask
	initial begin
		resetn = 1'b0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		#1 t_reset();
		t_points();
		t_enable();
		t_invalid();
		t_test();
		t_timeout();
		t_irq();
		test_done();
	end
endmodule
